// ==== src/addr_map_pkg.sv ====
/*
  constants, enumerations and carrier structs for the address decoder.
  assumes a core that presents 24-bit segment:offset addresses and an
  8-bit offset for the register region s:.
*/
package addr_map_pkg;
  // code rom: 16 kb at the bottom of segment ff:
  localparam logic [7:0] rom_seg = 8'hFF;
  localparam logic [15:0] rom_last = 16'h3FFF;
  // region 00: and the mirror of the upper 8 kb of rom
  localparam logic [7:0] seg_zero = 8'h00;
  localparam logic [15:0] mirror_base = 16'hE000;
  localparam logic [2:0] mirror_rom_hi = 3'b001;
  // on-chip data ram: 1 kb directly above the 32-byte register area
  localparam logic [15:0] ram_base = 16'h0020;
  localparam logic [15:0] ram_last = 16'h041F;
  localparam logic [15:0] bit_ram_last = 16'h00FF;
  // register-region addresses that alias register file bytes
  localparam logic [7:0] sfr_acc = 8'hE0;
  localparam logic [7:0] sfr_b = 8'hF0;
  localparam logic [7:0] sfr_sp = 8'h81;
  localparam logic [7:0] sfr_sph = 8'hBE;
  localparam logic [7:0] sfr_dpl = 8'h82;
  localparam logic [7:0] sfr_dph = 8'h83;
  localparam logic [7:0] sfr_dpxl = 8'h84;
  // register file byte index of each alias
  localparam logic [5:0] rf_acc = 6'h0B;
  localparam logic [5:0] rf_b = 6'h0A;
  localparam logic [5:0] rf_sp = 6'h3F;
  localparam logic [5:0] rf_sph = 6'h3E;
  localparam logic [5:0] rf_dpl = 6'h3B;
  localparam logic [5:0] rf_dph = 6'h3A;
  localparam logic [5:0] rf_dpxl = 6'h39;
  // edges after reset release before the synchronised strap is valid
  localparam logic [1:0] strap_settle = 2'h2;

  typedef enum logic [1:0] {space_code, space_data, space_sfr} space_t;
  typedef enum logic [1:0] {tgt_rom, tgt_ram, tgt_sfr, tgt_ext} target_t;

  typedef struct packed {
    logic valid;
    space_t space;
    logic [23:0] addr;
  } req_t;

  typedef struct packed {
    logic valid;
    target_t target;
    logic [23:0] addr;
    logic bit_ok;
    logic alias_hit;
    logic [5:0] alias_index;
  } resp_t;

  typedef struct packed {
    logic strap_sync1;
    logic strap_sync2;
    logic [1:0] settle;
    logic strap_held;
    logic ready;
    resp_t resp;
  } state_t;
endpackage : addr_map_pkg

// ==== src/code_data_address_decoder.sv ====
/*
  address decoder: steers each code fetch, data access and register
  access of the core to on-chip rom, on-chip ram, the register region
  or the external bus, one cycle after the request.
  assumes the core keeps the register file itself, holds requests off
  while ready is low, and that the mirror-disable bit comes from the
  configuration logic on clk_sys.
*/
// How it works
// - with the strap high, the 16 kb rom answers the bottom of ff:.
// - with the strap high, code outside the rom and the enabled mirror goes to the bus.
// - with the strap low, the rom is never used for code.
// - the 1 kb ram sits in 00: just above the 32-byte register area.
// - ram bytes 20h to ffh are flagged as bit addressable.
// - code accesses never land in the ram.
// - with mirror-disable clear, 00:e000 up mirrors the upper rom half.
// - with the strap low, the mirror goes out to ff:2000 to ff:3fff.
// - with mirror-disable set, region 00: never reaches the rom.
// - data that hits no on-chip memory is sent to the bus.
// - register accesses use their own region s: and no data address.
// - every register in s: is flagged as bit addressable.
// - core registers in s: are flagged with their register file byte.
// - the strap is caught once after reset and held from then on.
`timescale 1ns/10ps
module code_data_address_decoder (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // strap pin and configuration
  input wire logic external_access_strap,
  input wire logic onchip_code_mirror_disable,
  // request from the core
  input wire addr_map_pkg::req_t req,
  output logic ready,
  // decoded answer
  output addr_map_pkg::resp_t resp
);
  addr_map_pkg::state_t state;
  addr_map_pkg::state_t next_state;

  logic [7:0] seg;
  logic [15:0] off;
  logic [15:0] ram_off;
  logic in_rom;
  logic in_mirror;
  logic in_ram;
  logic alias_req;

  assign seg = req.addr[23:16];
  assign off = req.addr[15:0];
  assign ram_off = off - addr_map_pkg::ram_base;
  assign in_rom = (seg == addr_map_pkg::rom_seg) &&
    (off <= addr_map_pkg::rom_last);
  assign in_mirror = (seg == addr_map_pkg::seg_zero) &&
    (off >= addr_map_pkg::mirror_base);
  assign in_ram = (seg == addr_map_pkg::seg_zero) &&
    (off >= addr_map_pkg::ram_base) && (off <= addr_map_pkg::ram_last);
  // read only by the checks below: core registers with a file copy
  assign alias_req = req.addr[7:0] inside {addr_map_pkg::sfr_acc,
    addr_map_pkg::sfr_b, addr_map_pkg::sfr_sp, addr_map_pkg::sfr_sph,
    addr_map_pkg::sfr_dpl, addr_map_pkg::sfr_dph, addr_map_pkg::sfr_dpxl};

  always_comb begin
    next_state = state;
    // strap passes two flops, then is caught once and frozen
    next_state.strap_sync1 = external_access_strap;
    next_state.strap_sync2 = state.strap_sync1;
    if (!state.ready) begin
      if (state.settle == addr_map_pkg::strap_settle) begin
        next_state.strap_held = state.strap_sync2;
        next_state.ready = 1'b1;
      end else begin
        next_state.settle = state.settle + 2'h1;
      end
    end
    next_state.resp = '0;
    next_state.resp.target = addr_map_pkg::tgt_ext;
    if (state.ready && req.valid) begin
      next_state.resp.valid = 1'b1;
      // default: straight out on the external bus, address unchanged
      next_state.resp.target = addr_map_pkg::tgt_ext;
      next_state.resp.addr = req.addr;
      if (req.space == addr_map_pkg::space_sfr) begin
        // s: is its own space; no data address can reach it
        next_state.resp.target = addr_map_pkg::tgt_sfr;
        next_state.resp.addr = {16'h0000, req.addr[7:0]};
        next_state.resp.bit_ok = 1'b1;
        next_state.resp.alias_hit = 1'b1;
        if (req.addr[7:0] == addr_map_pkg::sfr_acc) begin
          next_state.resp.alias_index = addr_map_pkg::rf_acc;
        end else if (req.addr[7:0] == addr_map_pkg::sfr_b) begin
          next_state.resp.alias_index = addr_map_pkg::rf_b;
        end else if (req.addr[7:0] == addr_map_pkg::sfr_sp) begin
          next_state.resp.alias_index = addr_map_pkg::rf_sp;
        end else if (req.addr[7:0] == addr_map_pkg::sfr_sph) begin
          next_state.resp.alias_index = addr_map_pkg::rf_sph;
        end else if (req.addr[7:0] == addr_map_pkg::sfr_dpl) begin
          next_state.resp.alias_index = addr_map_pkg::rf_dpl;
        end else if (req.addr[7:0] == addr_map_pkg::sfr_dph) begin
          next_state.resp.alias_index = addr_map_pkg::rf_dph;
        end else if (req.addr[7:0] == addr_map_pkg::sfr_dpxl) begin
          next_state.resp.alias_index = addr_map_pkg::rf_dpxl;
        end else begin
          next_state.resp.alias_hit = 1'b0;
        end
      end else if (in_rom && state.strap_held) begin
        // rom answers code and data reads alike
        next_state.resp.target = addr_map_pkg::tgt_rom;
        next_state.resp.addr = {10'h000, off[13:0]};
      end else if (in_mirror && !onchip_code_mirror_disable) begin
        if (state.strap_held) begin
          next_state.resp.target = addr_map_pkg::tgt_rom;
          next_state.resp.addr = {10'h000, 1'b1, off[12:0]};
        end else begin
          // rom-less running: the copy lives in external ff:2000 up
          next_state.resp.addr = {addr_map_pkg::rom_seg,
            addr_map_pkg::mirror_rom_hi, off[12:0]};
        end
      end else if (in_ram && req.space == addr_map_pkg::space_data) begin
        // code fetches fall through to the bus instead
        next_state.resp.target = addr_map_pkg::tgt_ram;
        next_state.resp.addr = {14'h0000, ram_off[9:0]};
        next_state.resp.bit_ok = off <= addr_map_pkg::bit_ram_last;
      end
      // code with the strap low outside the mirror, code outside rom and mirror,
      // mirror with the bit set: all keep the external default above
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state <= '{default: '0, resp: '{default: '0,
        target: addr_map_pkg::tgt_ext}};
    end else begin
      state <= next_state;
    end
  end

  assign ready = state.ready;
  assign resp = state.resp;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  sequence taken_s;
    state.ready && req.valid;
  endsequence

  sequence code_s;
    taken_s ##0 req.space == addr_map_pkg::space_code;
  endsequence

  sequence data_s;
    taken_s ##0 req.space == addr_map_pkg::space_data;
  endsequence

  sequence sfr_s;
    taken_s ##0 req.space == addr_map_pkg::space_sfr;
  endsequence

  sequence mirror_on_s;
    taken_s ##0 req.space != addr_map_pkg::space_sfr && in_mirror &&
      !onchip_code_mirror_disable;
  endsequence

  rom_map_a: assert property (
    taken_s ##0 req.space != addr_map_pkg::space_sfr && in_rom &&
    state.strap_held |=> resp.target == addr_map_pkg::tgt_rom &&
    resp.addr == {10'h000, $past(req.addr[13:0])})
    else $error("rom window not decoded to rom");

  code_outside_a: assert property (
    code_s ##0 state.strap_held && !in_rom && !in_mirror
    |=> resp.target == addr_map_pkg::tgt_ext &&
    resp.addr == $past(req.addr))
    else $error("code outside rom not sent out");

  strap_low_a: assert property (
    code_s ##0 !state.strap_held |=> resp.target == addr_map_pkg::tgt_ext)
    else $error("rom used with strap low");

  ram_place_a: assert property (
    data_s ##0 in_ram |=> resp.target == addr_map_pkg::tgt_ram &&
    resp.addr[9:0] == $past(ram_off[9:0]) && resp.addr[23:10] == '0)
    else $error("ram placed wrongly");

  bit_ram_a: assert property (
    data_s ##0 in_ram |=> resp.bit_ok == ($past(off) <= 16'h00FF))
    else $error("ram bit flag wrong");

  code_no_ram_a: assert property (
    code_s |=> resp.target != addr_map_pkg::tgt_ram)
    else $error("code reached ram");

  mirror_rom_a: assert property (
    mirror_on_s ##0 state.strap_held |=>
    resp.target == addr_map_pkg::tgt_rom &&
    resp.addr[13:0] == {1'b1, $past(off[12:0])})
    else $error("mirror not mapped to upper rom");

  mirror_ext_a: assert property (
    mirror_on_s ##0 !state.strap_held |=>
    resp.target == addr_map_pkg::tgt_ext &&
    resp.addr == {8'hFF, 3'b001, $past(off[12:0])})
    else $error("mirror not sent to ff:2000 range");

  mirror_off_a: assert property (
    taken_s ##0 seg == 8'h00 && onchip_code_mirror_disable
    |=> resp.target != addr_map_pkg::tgt_rom)
    else $error("region 00: reached rom");

  data_ext_a: assert property (
    data_s ##0 !in_ram && !in_rom && !in_mirror
    |=> resp.target == addr_map_pkg::tgt_ext)
    else $error("unmapped data not sent out");

  sfr_region_a: assert property (
    taken_s |=> (resp.target == addr_map_pkg::tgt_sfr) ==
    $past(req.space == addr_map_pkg::space_sfr))
    else $error("register region mixed with data");

  sfr_bit_a: assert property (
    sfr_s |=> resp.bit_ok && resp.addr[23:8] == '0)
    else $error("register not bit addressable");

  acc_alias_a: assert property (
    sfr_s ##0 req.addr[7:0] == 8'hE0 |=> resp.alias_hit &&
    resp.alias_index == 6'h0B)
    else $error("accumulator alias missing");

  b_alias_a: assert property (
    sfr_s ##0 req.addr[7:0] == addr_map_pkg::sfr_b |=>
    resp.alias_hit && resp.alias_index == addr_map_pkg::rf_b)
    else $error("b register alias missing");

  sp_alias_a: assert property (
    sfr_s ##0 req.addr[7:0] == addr_map_pkg::sfr_sp |=>
    resp.alias_hit && resp.alias_index == addr_map_pkg::rf_sp)
    else $error("stack pointer alias missing");

  sph_alias_a: assert property (
    sfr_s ##0 req.addr[7:0] == addr_map_pkg::sfr_sph |=>
    resp.alias_hit && resp.alias_index == addr_map_pkg::rf_sph)
    else $error("stack pointer high alias missing");

  dpl_alias_a: assert property (
    sfr_s ##0 req.addr[7:0] == addr_map_pkg::sfr_dpl |=>
    resp.alias_hit && resp.alias_index == addr_map_pkg::rf_dpl)
    else $error("pointer low alias missing");

  dph_alias_a: assert property (
    sfr_s ##0 req.addr[7:0] == addr_map_pkg::sfr_dph |=>
    resp.alias_hit && resp.alias_index == addr_map_pkg::rf_dph)
    else $error("pointer high alias missing");

  dpxl_alias_a: assert property (
    sfr_s ##0 req.addr[7:0] == addr_map_pkg::sfr_dpxl |=>
    resp.alias_hit && resp.alias_index == addr_map_pkg::rf_dpxl)
    else $error("extended pointer alias missing");

  plain_sfr_a: assert property (
    sfr_s ##0 !alias_req |=> !resp.alias_hit && resp.alias_index == 6'h00)
    else $error("alias flagged on a plain register");

  alias_sfr_a: assert property (
    resp.alias_hit |-> resp.target == addr_map_pkg::tgt_sfr)
    else $error("alias flagged outside s:");

  strap_hold_a: assert property (
    state.ready |=> state.ready && $stable(state.strap_held))
    else $error("held strap changed");

  one_target_a: assert property (
    resp.valid == $past(state.ready && req.valid))
    else $error("answer without request or lost");

  refused_a: assert property (
    !state.ready |=> !resp.valid)
    else $error("answer given before ready");

  settle_count_a: assert property (
    !state.ready && state.settle != addr_map_pkg::strap_settle |=>
    !state.ready && state.settle == $past(state.settle) + 2'h1)
    else $error("settle count skipped");

  catch_once_a: assert property (
    !state.ready && state.settle == addr_map_pkg::strap_settle |=>
    state.ready && state.strap_held == $past(state.strap_sync2))
    else $error("strap not caught when ready rose");

  // between answers the register holds zeros with the bus as target
  idle_answer_a: assert property (
    !resp.valid |-> resp.target == addr_map_pkg::tgt_ext &&
    resp.addr == '0 && !resp.bit_ok && !resp.alias_hit)
    else $error("idle answer not cleared");

  onchip_addr_a: assert property (
    resp.valid && resp.target != addr_map_pkg::tgt_ext |->
    resp.addr[23:14] == '0)
    else $error("on-chip answer carries upper bits");

  bit_flag_a: assert property (
    resp.bit_ok |-> resp.valid &&
    (resp.target == addr_map_pkg::tgt_ram ||
    resp.target == addr_map_pkg::tgt_sfr))
    else $error("bit flag on a byte-only target");
endmodule : code_data_address_decoder

// ==== testbench/ext_memory_model.sv ====
/*
  far side: the external code and data memory on the bus. it tallies
  every answer that the decoder steers off-chip and keeps its address.
  assumes resp is registered on clk_sys and stands one cycle.
*/
`timescale 1ns/10ps
module ext_memory_model (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // decoded answer from the device
  input wire addr_map_pkg::resp_t resp,
  // what the bus has seen since reset
  output logic [15:0] ext_count,
  output logic [23:0] last_ext_addr
);
  // only whole bus cycles are counted; the model never stalls the core
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ext_count <= 16'h0000;
      last_ext_addr <= 24'h00_0000;
    end else if (resp.valid && resp.target == addr_map_pkg::tgt_ext) begin
      ext_count <= ext_count + 16'h0001;
      last_ext_addr <= resp.addr;
    end
  end
endmodule : ext_memory_model

// ==== testbench/code_data_address_decoder_tb.sv ====
/*
  self-checking bench for the address decoder: one task per scenario.
  assumes the one-cycle answer and the strap catch timing of the core
  side contract; inputs change on the falling edge only.
*/
`timescale 1ns/10ps
module code_data_address_decoder_tb;
  localparam int cycle_limit = 2000;
  localparam addr_map_pkg::target_t t_rom = addr_map_pkg::tgt_rom;
  localparam addr_map_pkg::target_t t_ram = addr_map_pkg::tgt_ram;
  localparam addr_map_pkg::target_t t_ext = addr_map_pkg::tgt_ext;
  localparam addr_map_pkg::space_t s_code = addr_map_pkg::space_code;
  localparam addr_map_pkg::space_t s_data = addr_map_pkg::space_data;
  // no answer: all fields zero, target parked on the bus
  localparam addr_map_pkg::resp_t r_idle = '{valid: 1'b0,
    target: addr_map_pkg::tgt_ext, default: '0};
  logic clk_sys;
  logic reset = 1'b1;
  logic external_access_strap = 1'b1;
  logic onchip_code_mirror_disable = 1'b1;
  addr_map_pkg::req_t req = '0;
  logic ready;
  addr_map_pkg::resp_t resp;
  logic [15:0] ext_count;
  logic [23:0] last_ext_addr;
  int n_errors = 0;
  int compares = 0;
  int cycles = 0;

  code_data_address_decoder DUT (
    .clk_sys(clk_sys),
    .reset(reset),
    .external_access_strap(external_access_strap),
    .onchip_code_mirror_disable(onchip_code_mirror_disable),
    .req(req),
    .ready(ready),
    .resp(resp)
  );

  ext_memory_model far_mem (
    .clk_sys(clk_sys),
    .reset(reset),
    .resp(resp),
    .ext_count(ext_count),
    .last_ext_addr(last_ext_addr)
  );

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  task automatic stop_test;
    $display("compares %0d, mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : stop_test

  // a hang is cut short here and judged like any other mismatch
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == cycle_limit) begin
      n_errors++;
      stop_test();
    end
  end

  task automatic check(input string what, input logic [34:0] seen,
                       input logic [34:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  function automatic addr_map_pkg::resp_t mk(
      input addr_map_pkg::target_t t, input logic [23:0] a, input logic b);
    mk = '0;
    mk.valid = 1'b1;
    mk.target = t;
    mk.addr = a;
    mk.bit_ok = b;
  endfunction : mk

  // one request, its answer one edge later, then the idle zeros
  task automatic go(input addr_map_pkg::space_t sp, input logic [23:0] a,
                    input addr_map_pkg::resp_t exp);
    req = '{1'b1, sp, a};
    @(negedge clk_sys);
    req.valid = 1'b0;
    check("resp", resp, exp);
    @(negedge clk_sys);
    check("resp idle", resp, r_idle);
  endtask : go

  // requests held up before ready must vanish without an answer
  task automatic do_reset(input logic strap);
    int n;
    external_access_strap = strap;
    reset = 1'b1;
    req = '{1'b1, s_code, 24'hff_0000};
    repeat (20) @(negedge clk_sys);
    reset = 1'b0;
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
      check("refused", resp, r_idle);
    end while (ready !== 1'b1 && n < 10);
    req.valid = 1'b0;
    check("ready edge", 35'(n), 35'd3);
    // the held request at the ready edge must not echo one cycle later
    @(negedge clk_sys);
    check("refused late", resp, r_idle);
  endtask : do_reset

  task automatic test_code_map;
    do_reset(1'b1);
    go(s_code, 24'hff_0123, mk(t_rom, 24'h00_0123, 1'b0));
    go(s_code, 24'hff_3fff, mk(t_rom, 24'h00_3fff, 1'b0));
    go(s_data, 24'hff_0200, mk(t_rom, 24'h00_0200, 1'b0));
    go(s_code, 24'hff_4000, mk(t_ext, 24'hff_4000, 1'b0));
    go(s_code, 24'h01_0000, mk(t_ext, 24'h01_0000, 1'b0));
    go(s_code, 24'h00_0030, mk(t_ext, 24'h00_0030, 1'b0));
    external_access_strap = 1'b0;
    repeat (3) @(negedge clk_sys);
    go(s_code, 24'hff_0000, mk(t_rom, 24'h00_0000, 1'b0));
    $display("test code map done");
  endtask : test_code_map

  task automatic test_data_map;
    go(s_data, 24'h00_0020, mk(t_ram, 24'h00_0000, 1'b1));
    go(s_data, 24'h00_00ff, mk(t_ram, 24'h00_00df, 1'b1));
    go(s_data, 24'h00_0100, mk(t_ram, 24'h00_00e0, 1'b0));
    go(s_data, 24'h00_041f, mk(t_ram, 24'h00_03ff, 1'b0));
    go(s_data, 24'h00_0420, mk(t_ext, 24'h00_0420, 1'b0));
    go(s_data, 24'h00_e010, mk(t_ext, 24'h00_e010, 1'b0));
    onchip_code_mirror_disable = 1'b0;
    go(s_code, 24'h00_e010, mk(t_rom, 24'h00_2010, 1'b0));
    go(s_data, 24'h00_ffff, mk(t_rom, 24'h00_3fff, 1'b0));
    onchip_code_mirror_disable = 1'b1;
    go(s_code, 24'h00_e010, mk(t_ext, 24'h00_e010, 1'b0));
    $display("test data map done");
  endtask : test_data_map

  task automatic test_sfr;
    logic [7:0] adr [8] = '{addr_map_pkg::sfr_acc, addr_map_pkg::sfr_b,
      addr_map_pkg::sfr_sp, addr_map_pkg::sfr_sph, addr_map_pkg::sfr_dpl,
      addr_map_pkg::sfr_dph, addr_map_pkg::sfr_dpxl, 8'h98};
    logic [5:0] idx [8] = '{addr_map_pkg::rf_acc, addr_map_pkg::rf_b,
      addr_map_pkg::rf_sp, addr_map_pkg::rf_sph, addr_map_pkg::rf_dpl,
      addr_map_pkg::rf_dph, addr_map_pkg::rf_dpxl, 6'h00};
    addr_map_pkg::resp_t e;
    for (int i = 0; i < 8; i++) begin
      e = mk(addr_map_pkg::tgt_sfr, {16'h0000, adr[i]}, 1'b1);
      e.alias_hit = (i < 7);
      e.alias_index = idx[i];
      go(addr_map_pkg::space_sfr, {16'h0020, adr[i]}, e);
    end
    $display("test sfr done");
  endtask : test_sfr

  task automatic test_back_to_back;
    req = '{1'b1, s_data, 24'h00_0020};
    @(negedge clk_sys);
    req = '{1'b1, s_code, 24'hff_1000};
    check("b2b first", resp, mk(t_ram, 24'h00_0000, 1'b1));
    @(negedge clk_sys);
    req.valid = 1'b0;
    check("b2b second", resp, mk(t_rom, 24'h00_1000, 1'b0));
    @(negedge clk_sys);
    check("b2b idle", resp, r_idle);
    $display("test back to back done");
  endtask : test_back_to_back

  // a board with a rom-less part holds the strap low
  task automatic test_strap_low;
    do_reset(1'b0);
    onchip_code_mirror_disable = 1'b0;
    go(s_code, 24'hff_0123, mk(t_ext, 24'hff_0123, 1'b0));
    go(s_data, 24'hff_0123, mk(t_ext, 24'hff_0123, 1'b0));
    go(s_code, 24'h00_e010, mk(t_ext, 24'hff_2010, 1'b0));
    check("ext count", 35'(ext_count), 35'd3);
    check("ext addr", 35'(last_ext_addr), 35'h00ff_2010);
    $display("test strap low done");
  endtask : test_strap_low

  initial begin
    @(negedge clk_sys);
    test_code_map();
    test_data_map();
    test_sfr();
    test_back_to_back();
    test_strap_low();
    stop_test();
  end
endmodule : code_data_address_decoder_tb
